/* rtl/rcob_defines.svh */
// Constants for the command request block builder: register offsets,
// field positions and fixed field values of the request block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef RCOB_DEFINES_SVH
`define RCOB_DEFINES_SVH

// Register byte offsets on the Wishbone slave
`define RCOB_ADR_CTRL       8'h00
`define RCOB_ADR_STAT       8'h04
`define RCOB_ADR_DATA_HI    8'h08
`define RCOB_ADR_DATA_LO    8'h0c
`define RCOB_ADR_SIZES      8'h10
`define RCOB_ADR_NEXT_HI    8'h14
`define RCOB_ADR_NEXT_LO    8'h18
`define RCOB_ADR_SQ_HI      8'h1c
`define RCOB_ADR_SQ_LO      8'h20
`define RCOB_ADR_TSTAT      8'h24

// Control register fields
`define RCOB_CTRL_START     0
`define RCOB_CTRL_PTAB      1
`define RCOB_CTRL_PSZ_LSB   2
`define RCOB_CTRL_PSZ_MSB   4

// Status register fields
`define RCOB_STAT_BUSY      0
`define RCOB_STAT_DONE      1
`define RCOB_STAT_SZERR     2

// Sizes register fields
`define RCOB_SIZE_DATA_MSB  15
`define RCOB_SIZE_RESP_LSB  16

// Fixed request block field values
`define RCOB_NOTIFY_VAL     1'h1
`define RCOB_REQUEST_FORMAT_CODE_VAL     2'h0
`define RCOB_RSV1_VAL       1'h0
`define RCOB_DIR_VAL        1'h1
`define RCOB_SPD_VAL        3'h2
`define RCOB_MAXPAY_VAL     4'h9
`define RCOB_PSZ_NONE       3'h0
`define RCOB_MIN_DSIZE      16'h0050
`define RCOB_OPCODE_VAL     8'h08
`define RCOB_LUN_VAL        3'h1
`define RCOB_RSV4_VAL       4'h0
`define RCOB_AEN_VAL        1'h0
`define RCOB_BYTE_ZERO      8'h00
`define RCOB_WORD_ZERO      32'h0000_0000

// Request block word indices
`define RCOB_W_NEXT_HI      3'h0
`define RCOB_W_NEXT_LO      3'h1
`define RCOB_W_DATA_HI      3'h2
`define RCOB_W_DATA_LO      3'h3
`define RCOB_W_FLAGS        3'h4
`define RCOB_W_CMD          3'h5
`define RCOB_W_CTRL         3'h6

`endif

/* rtl/rcob_pkg.sv */
// Types shared by the request block builder and its word formatter.
// Holds its own state codes; takes no constants from rcob_defines.svh.
package rcob_pkg;

    typedef enum logic [1:0] {
        RCOB_IDLE   = 2'b01,
        RCOB_POSTED = 2'b10
    } rcob_fsm_t;

    typedef struct packed {
        logic [63:0] next_orb;
        logic [63:0] data_addr;
        logic        page_table;
        logic [2:0]  page_size;
        logic [15:0] data_size;
        logic [15:0] resp_len;
    } rcob_orb_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } rcob_wb_req_t;

    typedef struct packed {
        logic       rd_en;
        logic [2:0] idx;
    } rcob_fetch_t;

    typedef struct packed {
        logic        we;
        logic [31:0] word;
    } rcob_tstat_t;

endpackage : rcob_pkg

/* rtl/rcob_orb_format.sv */
// Formatter for one 32-bit word of the command request block.
// Assumes a stable field snapshot; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "rcob_defines.svh"

module rcob_orb_format (
    // Field snapshot
    input  wire rcob_pkg::rcob_orb_t orb,
    // Word select and result
    input  wire logic [2:0]          idx,
    output logic [31:0]              word
);
    import rcob_pkg::*;

    always_comb
    begin
        case (idx)
            // (R01) Pointer as given
            `RCOB_W_NEXT_HI: word = orb.next_orb[63:32];
            `RCOB_W_NEXT_LO: word = orb.next_orb[31:0];
            // (R02) Buffer address
            `RCOB_W_DATA_HI: word = orb.data_addr[63:32];
            `RCOB_W_DATA_LO: word = orb.data_addr[31:0];
            // (R03) (R05) (R06) (R07) (R08) (R09) Fixed flag fields, then page flag, page size and data size
            `RCOB_W_FLAGS:   word = {`RCOB_NOTIFY_VAL, `RCOB_REQUEST_FORMAT_CODE_VAL, `RCOB_RSV1_VAL,
                                     `RCOB_DIR_VAL, `RCOB_SPD_VAL, `RCOB_MAXPAY_VAL,
                                     orb.page_table, orb.page_size, orb.data_size};
            // (R13) (R14) (R15) Command bytes
            `RCOB_W_CMD:     word = {`RCOB_OPCODE_VAL, `RCOB_LUN_VAL, `RCOB_RSV4_VAL,
                                     `RCOB_AEN_VAL, orb.resp_len};
            `RCOB_W_CTRL:    word = {`RCOB_BYTE_ZERO, `RCOB_BYTE_ZERO,
                                     `RCOB_BYTE_ZERO, `RCOB_BYTE_ZERO};
            default:         word = `RCOB_WORD_ZERO;
        endcase
    end

endmodule // rcob_orb_format
`default_nettype wire

/* rtl/rcob_host.sv */
// Host controller that builds a command request block for the
// recorder media target, posts it for fetch and collects the status.
// Assumes a Wishbone classic master for software and a target that
// fetches words by index and posts one status word per request.
//
// Summary of operation
// (R01) Next-request pointer passed in protocol format
// (R02) Data descriptor holds receive buffer address
// (R03) Completion notification flag always one
// (R04) Target posts status block to status queue
// (R05) Request format code always zero
// (R06) Reserved bit beside format code zero
// (R07) Direction bit one, target to host
// (R08) Link speed code fixed at two
// (R09) Maximum transfer length code fixed nine
// (R10) Target accepts page table flag either way
// (R11) Page size zero when page flag clear
// (R12) Data size is buffer size, at least 80
// (R13) Logical unit field fixed at one
// (R14) Command reserved bits and event flag zero
// (R15) Response length equals expected response length
`timescale 1ns/100ps
`default_nettype none
`include "rcob_defines.svh"

module rcob_host (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    // Wishbone slave
    input  wire rcob_pkg::rcob_wb_req_t wb_req,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    // Target fetch port
    input  wire rcob_pkg::rcob_fetch_t fetch,
    output logic [31:0]                orb_rd_data,
    output logic                       orb_ready,
    // Target status port
    input  wire rcob_pkg::rcob_tstat_t tstat,
    output logic [63:0]                status_q_addr
);
    import rcob_pkg::*;

    typedef struct packed {
        rcob_fsm_t   fsm;
        logic        ack;
        logic [31:0] rdat;
        logic [31:0] orb_rdat;
        logic        ptab;
        logic [2:0]  psz;
        logic [63:0] data_addr;
        logic [63:0] next_orb;
        logic [15:0] data_size;
        logic [15:0] resp_len;
        logic [63:0] sq_addr;
        logic        done;
        logic        size_err;
        logic [31:0] tword;
        rcob_orb_t   snap;
    } rcob_state_t;

    rcob_state_t st;
    rcob_state_t next_st;
    logic [31:0] fmt_word;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    // Byte-lane merge of a write
    function automatic logic [31:0] rcob_merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    rcob_orb_format u_fmt (
        .orb  (st.snap),
        .idx  (fetch.idx),
        .word (fmt_word)
    );

    assign wr_hit = wb_req.cyc && wb_req.stb && wb_req.we && !st.ack;
    assign rd_hit = wb_req.cyc && wb_req.stb && !wb_req.we && !st.ack;

    always_comb
    begin
        ctrl_word = `RCOB_WORD_ZERO;
        ctrl_word[`RCOB_CTRL_PTAB] = st.ptab;
        ctrl_word[`RCOB_CTRL_PSZ_MSB:`RCOB_CTRL_PSZ_LSB] = st.psz;
        stat_word = `RCOB_WORD_ZERO;
        stat_word[`RCOB_STAT_BUSY] = (st.fsm == RCOB_POSTED);
        stat_word[`RCOB_STAT_DONE] = st.done;
        stat_word[`RCOB_STAT_SZERR] = st.size_err;
    end

    always_comb
    begin
        logic [31:0] cw;
        logic [31:0] sz;
        logic        start;
        logic        clr_done;
        logic        clr_err;
        cw = `RCOB_WORD_ZERO;
        sz = `RCOB_WORD_ZERO;
        start = 1'b0;
        clr_done = 1'b0;
        clr_err = 1'b0;
        next_st = st;

        // Bus answer one cycle after the request
        next_st.ack = wb_req.cyc && wb_req.stb && !st.ack;

        // Register writes
        if (wr_hit)
        begin
            case (wb_req.adr)
                `RCOB_ADR_CTRL:
                begin
                    cw = rcob_merge(ctrl_word, wb_req.dat, wb_req.sel);
                    next_st.ptab = cw[`RCOB_CTRL_PTAB];
                    next_st.psz = cw[`RCOB_CTRL_PSZ_MSB:`RCOB_CTRL_PSZ_LSB];
                    start = wb_req.sel[0] && wb_req.dat[`RCOB_CTRL_START];
                end
                `RCOB_ADR_STAT:
                begin
                    clr_done = wb_req.sel[0] && wb_req.dat[`RCOB_STAT_DONE];
                    clr_err = wb_req.sel[0] && wb_req.dat[`RCOB_STAT_SZERR];
                end
                `RCOB_ADR_DATA_HI:
                begin
                    next_st.data_addr[63:32] =
                        rcob_merge(st.data_addr[63:32], wb_req.dat, wb_req.sel);
                end
                `RCOB_ADR_DATA_LO:
                begin
                    next_st.data_addr[31:0] =
                        rcob_merge(st.data_addr[31:0], wb_req.dat, wb_req.sel);
                end
                `RCOB_ADR_SIZES:
                begin
                    sz = rcob_merge({st.resp_len, st.data_size}, wb_req.dat, wb_req.sel);
                    next_st.data_size = sz[`RCOB_SIZE_DATA_MSB:0];
                    next_st.resp_len = sz[31:`RCOB_SIZE_RESP_LSB];
                end
                `RCOB_ADR_NEXT_HI:
                begin
                    next_st.next_orb[63:32] =
                        rcob_merge(st.next_orb[63:32], wb_req.dat, wb_req.sel);
                end
                `RCOB_ADR_NEXT_LO:
                begin
                    next_st.next_orb[31:0] =
                        rcob_merge(st.next_orb[31:0], wb_req.dat, wb_req.sel);
                end
                `RCOB_ADR_SQ_HI:
                begin
                    next_st.sq_addr[63:32] =
                        rcob_merge(st.sq_addr[63:32], wb_req.dat, wb_req.sel);
                end
                `RCOB_ADR_SQ_LO:
                begin
                    next_st.sq_addr[31:0] =
                        rcob_merge(st.sq_addr[31:0], wb_req.dat, wb_req.sel);
                end
                default:
                begin
                    next_st.ack = wb_req.cyc && wb_req.stb && !st.ack;
                end
            endcase
        end

        // Register reads, unmapped reads as zero
        if (rd_hit)
        begin
            case (wb_req.adr)
                `RCOB_ADR_CTRL:
                begin
                    next_st.rdat = ctrl_word;
                end
                `RCOB_ADR_STAT:
                begin
                    next_st.rdat = stat_word;
                end
                `RCOB_ADR_DATA_HI:
                begin
                    next_st.rdat = st.data_addr[63:32];
                end
                `RCOB_ADR_DATA_LO:
                begin
                    next_st.rdat = st.data_addr[31:0];
                end
                `RCOB_ADR_SIZES:
                begin
                    next_st.rdat = {st.resp_len, st.data_size};
                end
                `RCOB_ADR_NEXT_HI:
                begin
                    next_st.rdat = st.next_orb[63:32];
                end
                `RCOB_ADR_NEXT_LO:
                begin
                    next_st.rdat = st.next_orb[31:0];
                end
                `RCOB_ADR_SQ_HI:
                begin
                    next_st.rdat = st.sq_addr[63:32];
                end
                `RCOB_ADR_SQ_LO:
                begin
                    next_st.rdat = st.sq_addr[31:0];
                end
                `RCOB_ADR_TSTAT:
                begin
                    next_st.rdat = st.tword;
                end
                default:
                begin
                    next_st.rdat = `RCOB_WORD_ZERO;
                end
            endcase
        end

        // Sticky flags, clear by writing one
        if (clr_done)
        begin
            next_st.done = 1'b0;
        end
        if (clr_err)
        begin
            next_st.size_err = 1'b0;
        end

        // Fetched word registered for the target
        if (fetch.rd_en)
        begin
            next_st.orb_rdat = fmt_word;
        end

        case (st.fsm)
            RCOB_IDLE:
            begin
                if (start)
                begin
                    // (R12) Refuse a buffer under the minimum
                    if (st.data_size < `RCOB_MIN_DSIZE)
                    begin
                        next_st.size_err = 1'b1;
                    end
                    else
                    begin
                        // (R01) (R02) Snapshot pointer and buffer
                        next_st.snap.next_orb = st.next_orb;
                        next_st.snap.data_addr = st.data_addr;
                        // (R10) Page flag passed as software chose
                        next_st.snap.page_table = st.ptab;
                        // (R11) Granule zeroed without page table
                        next_st.snap.page_size = st.ptab ? st.psz : `RCOB_PSZ_NONE;
                        // (R12) Data size is the buffer size
                        next_st.snap.data_size = st.data_size;
                        // (R15) Expected response length
                        next_st.snap.resp_len = st.resp_len;
                        next_st.fsm = RCOB_POSTED;
                    end
                end
            end
            RCOB_POSTED:
            begin
                // (R04) Completion by posted status block
                if (tstat.we)
                begin
                    next_st.tword = tstat.word;
                    next_st.done = 1'b1;
                    next_st.fsm = RCOB_IDLE;
                end
            end
            default:
            begin
                next_st.fsm = RCOB_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.fsm <= RCOB_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.rdat;
    assign wb_ack_o = st.ack;
    assign orb_rd_data = st.orb_rdat;
    assign orb_ready = (st.fsm == RCOB_POSTED);
    assign status_q_addr = st.sq_addr;

endmodule // rcob_host
`default_nettype wire

/* testbench/rcob_target_model.sv */
// Behavioural recorder target: fetches the posted block, posts status.
// Assumes the host formats a word one cycle after each fetch edge.
`timescale 1ns/100ps
`default_nettype none
module rcob_target_model (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            rst_b,
    // Host side
    input  wire logic            orb_ready,
    input  wire logic [31:0]     orb_rd_data,
    output var rcob_pkg::rcob_fetch_t fetch,
    output var rcob_pkg::rcob_tstat_t tstat,
    // Bench control
    input  wire logic [3:0]      lag,
    input  wire logic [31:0]     sword,
    output var logic [31:0]      got [8]
);
    import rcob_pkg::*;
    int k;
    initial
    begin
        fetch = '0;
        tstat = '0;
        forever
        begin
            @(posedge mclk);
            if (rst_b && orb_ready)
            begin
                for (k = 0; k < 10; k++)
                begin
                    if (k > 1)
                        got[k-2] = orb_rd_data;
                    fetch <= '{k < 8, k[2:0]};
                    @(posedge mclk);
                end
                repeat (lag) @(posedge mclk);
                tstat <= '{1'b1, sword};
                @(posedge mclk);
                tstat.we <= 1'b0;
            end
        end
    end
endmodule // rcob_target_model
`default_nettype wire

/* testbench/rcob_host_assertions.sv */
// Checker on the host controller ports.
// Assumes one clock domain and the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
module rcob_host_checker (
    // Clock and reset
    input wire logic                   mclk,
    input wire logic                   rst_b,
    // Wishbone slave
    input wire rcob_pkg::rcob_wb_req_t wb_req,
    input wire logic [31:0]            wb_dat_o,
    input wire logic                   wb_ack_o,
    // Target ports
    input wire rcob_pkg::rcob_fetch_t  fetch,
    input wire logic [31:0]            orb_rd_data,
    input wire logic                   orb_ready,
    input wire rcob_pkg::rcob_tstat_t  tstat,
    input wire logic [63:0]            status_q_addr
);
    import rcob_pkg::*;
    logic start_q;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // Start request seen
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            start_q <= 1'b0;
        else
            start_q <= wb_req.cyc && wb_req.stb && wb_req.we && wb_req.adr == 8'h00
                && wb_req.dat[0];
    a_ack_follows: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_flags_word:
    assert property (fetch.rd_en && fetch.idx == 3'h4 |=> orb_rd_data[31:20] == 12'h8a9)
        else $error("flags word wrong");
    a_page_zero:
    assert property (fetch.rd_en && fetch.idx == 3'h4 |=> orb_rd_data[19]
        || orb_rd_data[18:16] == 3'h0)
        else $error("page size not zero");
    a_cmd_word:
    assert property (fetch.rd_en && fetch.idx == 3'h5 |=> orb_rd_data[31:16] == 16'h0820)
        else $error("command word wrong");
    a_size_floor:
    assert property (fetch.rd_en && fetch.idx == 3'h4 && orb_ready
        |=> orb_rd_data[15:0] >= 16'h0050)
        else $error("data size under floor");
    a_status_ends:
    assert property (orb_ready && tstat.we |=> !orb_ready)
        else $error("status did not end request");
    a_ready_cause:
    assert property ($rose(orb_ready) |-> start_q)
        else $error("request posted without start");
endmodule // rcob_host_checker
bind rcob_host rcob_host_checker u_rcob_host_checker (
    .mclk(mclk), .rst_b(rst_b), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fetch(fetch), .orb_rd_data(orb_rd_data),
    .orb_ready(orb_ready), .tstat(tstat), .status_q_addr(status_q_addr));
`default_nettype wire

/* testbench/rcob_host_tb_top.sv */
// Testbench for the request block builder with a target model.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module rcob_host_tb_top;
    import rcob_pkg::*;
    logic mclk = 1'b0, rst_b = 1'b0, wb_ack_o, orb_ready, p;
    rcob_wb_req_t wb_req = '0;
    rcob_fetch_t fetch;
    rcob_tstat_t tstat;
    logic [31:0] wb_dat_o, orb_rd_data, rd, sword = '0, got [8], w [$];
    logic [63:0] status_q_addr, nx, da, sq;
    logic [3:0] lag = 4'h0;
    logic [2:0] ps;
    logic [15:0] ds, rl;
    int num_errors = 0, checks = 0, seed = 32'h9422, i, j, t;
    always #50 mclk = ~mclk;
    rcob_host u_rcob_host (.mclk(mclk), .rst_b(rst_b), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fetch(fetch),
        .orb_rd_data(orb_rd_data), .orb_ready(orb_ready), .tstat(tstat),
        .status_q_addr(status_q_addr));
    rcob_target_model u_rcob_target_model (.mclk(mclk), .rst_b(rst_b),
        .orb_ready(orb_ready), .orb_rd_data(orb_rd_data), .fetch(fetch),
        .tstat(tstat), .lag(lag), .sword(sword), .got(got));
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        do
        begin
            @(posedge mclk);
        end
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_req <= '0;
        @(posedge mclk);
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #500000;
        num_errors++;
        complete_run();
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        // Reset values, unmapped write ignored
        wb(1'b1, 8'h28, 32'hffff_ffff);
        for (i = 0; i <= 8'h28; i += 4)
        begin
            wb(1'b0, i[7:0], 32'h0);
            chk(rd, 32'h0);
        end
        // Undersized buffer refused
        wb(1'b1, 8'h10, 32'h0000_004f);
        wb(1'b1, 8'h00, 32'h1);
        chk(orb_ready, 1'b0);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h4);
        wb(1'b1, 8'h04, 32'h4);
        for (j = 0; j < 6; j++)
        begin
            nx = {$random(seed), $random(seed)};
            da = {$random(seed), $random(seed)};
            sq = {$random(seed), $random(seed)};
            p = j[0];
            ps = $random(seed);
            ds = j ? $random(seed) | 16'h0100 : 16'h0050;
            rl = $random(seed);
            sword <= $random(seed);
            lag <= j[1] ? 4'h6 : 4'h0;
            wb(1'b1, 8'h08, da[63:32]);
            wb(1'b1, 8'h0c, da[31:0]);
            wb(1'b1, 8'h14, nx[63:32]);
            wb(1'b1, 8'h18, nx[31:0]);
            wb(1'b1, 8'h1c, sq[63:32]);
            wb(1'b1, 8'h20, sq[31:0]);
            wb(1'b1, 8'h10, {rl, ds});
            wb(1'b1, 8'h00, {27'h0, ps, p, 1'b0});
            wb(1'b1, 8'h00, {27'h0, ps, p, 1'b1});
            chk(orb_ready, 1'b1);
            for (t = 0; t < 100 && orb_ready !== 1'b0; t++)
                @(posedge mclk);
            chk(orb_ready, 1'b0);
            w = '{nx[63:32], nx[31:0], da[63:32], da[31:0],
                {1'b1, 2'h0, 1'b0, 1'b1, 3'h2, 4'h9, p, p ? ps : 3'h0, ds},
                {8'h08, 3'h1, 4'h0, 1'b0, rl}, 32'h0, 32'h0};
            for (i = 0; i < 8; i++)
                chk(got[i], w[i]);
            chk(status_q_addr, sq);
            wb(1'b0, 8'h04, 32'h0);
            chk(rd, 32'h2);
            wb(1'b0, 8'h24, 32'h0);
            chk(rd, sword);
            wb(1'b1, 8'h04, 32'h2);
        end
        complete_run();
    end
endmodule // rcob_host_tb_top
`default_nettype wire
